// [core/sysins_pkg.sv]
// Package for the system instruction unit: op codes, special register
// selectors, status word fields and register offsets.
// Assumes a single 50 MHz core clock and an APB register port.
package sysins_pkg;

   // Operation codes issued by the instruction stream
   typedef enum logic [3:0]
   {
      SYSINS_OP_NONE = 4'h0,
      SYSINS_OP_CHANGE_STATE = 4'h1,
      SYSINS_OP_ORDER_BARRIER = 4'h2,
      SYSINS_OP_SYNC_BARRIER = 4'h3,
      SYSINS_OP_FETCH_BARRIER = 4'h4,
      SYSINS_OP_SPECIAL_READ = 4'h5,
      SYSINS_OP_SPECIAL_WRITE = 4'h6,
      SYSINS_OP_NOP = 4'h7,
      SYSINS_OP_SEND_EVENT = 4'h8,
      SYSINS_OP_SUPERVISOR_CALL = 4'h9,
      SYSINS_OP_WAIT_EVENT = 4'hA,
      SYSINS_OP_WAIT_INTERRUPT = 4'hB,
      SYSINS_OP_MEMORY = 4'hC
   } sysins_op_t;

   // Special register selectors
   localparam logic [3:0] SPEC_STATUS = 4'h0;
   localparam logic [3:0] SPEC_INT_MASK = 4'h1;
   localparam logic [3:0] SPEC_FAULT_MASK = 4'h2;
   localparam logic [3:0] SPEC_PRIO_LEVEL = 4'h3;
   localparam logic [3:0] SPEC_PRIO_RAISE = 4'h4;
   localparam logic [3:0] SPEC_CONTROL = 4'h5;

   // Status word: condition flags and saturation bit in the top five bits
   localparam int STATUS_FLAG_LSB = 27;
   localparam logic [31:0] STATUS_APP_MASK = 32'hF8000000;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;

   // Priority mask level width
   localparam int PRIO_W = 8;
   localparam logic [7:0] PRIO_RESET = 8'h00;

   // Change-state flag field bits
   localparam int CPS_FLAG_INT = 0;
   localparam int CPS_FLAG_FAULT = 1;

   // APB register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_PRIO = 8'h0C;
   localparam logic [7:0] REG_CONTROL = 8'h10;

   // Control register fields
   localparam int CTRL_WAKE_PEND = 0;
   localparam int CTRL_DEBUG_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

endpackage

// [core/sysins_unit.sv]
// System instruction unit: executes mask changes, barriers, special
// register moves, event and wait hints, and supervisor calls.
// Assumes one instruction offered at a time with valid/ready, memory
// accesses tracked by an outstanding count from the memory system.
//
// Summary of operation
// [RQ1] Change-state sets or clears selected mask bits
// [RQ2] Unprivileged change-state has no effect
// [RQ3] These ops never touch condition flags
// [RQ4] Order barrier: earlier accesses finish before later
// [RQ5] Order barrier never stalls non-memory instructions
// [RQ6] Sync barrier stalls every later instruction
// [RQ7] Sync barrier completes when accesses all done
// [RQ8] Fetch barrier flushes pipeline and refetches
// [RQ9] Raise alias reads current priority level
// [RQ10] Unprivileged write reaches only status word
// [RQ11] Unprivileged status write ignores non-flag bits
// [RQ12] Raise alias writes only nonzero higher priority
// [RQ13] Status write updates flags from source
// [RQ14] No-operation completes at once, no delay
// [RQ15] Send-event signals out, sets event register
// [RQ16] Supervisor call raises exception, immediate ignored
// [RQ17] Wait-event with zero register sleeps until wake
// [RQ18] Wait-event with set register clears, continues
// [RQ19] Wait-interrupt sleeps until exception or debug
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module sysins_unit
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic op_valid,
   input wire sysins_pkg::sysins_op_t op_code,
   input wire logic [1:0] op_flags,
   input wire logic op_set,
   input wire logic [3:0] op_spec,
   input wire logic [31:0] op_src,
   input wire logic [7:0] op_imm,
   input wire logic op_privileged,
   output logic op_ready,
   output logic [31:0] read_data,
   output logic read_valid,
   input wire logic [3:0] mem_outstanding,
   output logic mem_issue_ok,
   output logic pipe_flush,
   output logic event_out,
   input wire logic event_in,
   output logic svc_raise,
   input wire logic exc_unmasked,
   input wire logic exc_pending,
   input wire logic exc_any,
   input wire logic debug_req,
   output logic sleeping,
   output logic int_mask,
   output logic fault_mask,
   output logic [7:0] prio_level,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   typedef enum logic [1:0]
   {
      SYSINS_RUN,
      SYSINS_SYNC,
      SYSINS_WAIT_EV,
      SYSINS_WAIT_INT
   } sysins_state_t;

   typedef struct packed
   {
      sysins_state_t state;
      logic int_mask;
      logic fault_mask;
      logic [7:0] prio;
      logic [31:0] status;
      logic [31:0] control;
      logic event_reg;
      logic order_hold;
      logic [1:0] ctrl;
      logic [31:0] read_data;
      logic read_valid;
      logic flush;
      logic event_out;
      logic supervisor_call_op;
      logic [31:0] prdata;
   } sysins_regs_t;

   sysins_regs_t r;
   sysins_regs_t next_r;

   ////////////////////////////////////////////////////////////////////
   // Priority raise test, used by core write and its check
   function automatic logic raise_ok(input logic [7:0] cur, input logic [7:0] nv);
      raise_ok = (nv != 8'h00) && ((cur == 8'h00) || (nv < cur));
   endfunction

   logic apb_access;
   logic wake_event;
   logic wake_int;
   logic accept;

   always_comb
   begin
      apb_access = psel && penable;
      // Pending and debug wakes gated by wake-on-pending and debug enable
      wake_event = exc_unmasked || (exc_pending && r.ctrl[sysins_pkg::CTRL_WAKE_PEND]) ||
         (debug_req && r.ctrl[sysins_pkg::CTRL_DEBUG_EN]) || event_in; // [RQ17]
      wake_int = exc_any || debug_req; // [RQ19]
      accept = op_valid && op_ready;
   end

   // Handshakes: any stall state holds the stream
   always_comb
   begin
      op_ready = (r.state == SYSINS_RUN); // [RQ6]
      // Memory ops wait while an order barrier is open; others flow on
      mem_issue_ok = !r.order_hold && (r.state == SYSINS_RUN); // [RQ4] [RQ5]
      sleeping = (r.state == SYSINS_WAIT_EV) || (r.state == SYSINS_WAIT_INT);
      pready = 1'b1;
      pslverr = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      next_r = r;
      next_r.read_valid = 1'b0;
      next_r.flush = 1'b0;
      next_r.event_out = 1'b0;
      next_r.supervisor_call_op = 1'b0;
      // Order barrier releases once earlier accesses drain
      if (r.order_hold && (mem_outstanding == 4'h0))
      begin
         next_r.order_hold = 1'b0; // [RQ4]
      end
      case (r.state)
         SYSINS_RUN:
         begin
            if (accept)
            begin
               case (op_code)
                  sysins_pkg::SYSINS_OP_CHANGE_STATE:
                  begin
                     // Flags untouched; unprivileged is a no-op
                     if (op_privileged) // [RQ2] [RQ3]
                     begin
                        if (op_flags[sysins_pkg::CPS_FLAG_INT])
                        begin
                           next_r.int_mask = op_set; // [RQ1]
                        end
                        if (op_flags[sysins_pkg::CPS_FLAG_FAULT])
                        begin
                           next_r.fault_mask = op_set; // [RQ1]
                        end
                     end
                  end
                  sysins_pkg::SYSINS_OP_ORDER_BARRIER:
                  begin
                     next_r.order_hold = (mem_outstanding != 4'h0); // [RQ4]
                  end
                  sysins_pkg::SYSINS_OP_SYNC_BARRIER:
                  begin
                     if (mem_outstanding != 4'h0)
                     begin
                        next_r.state = SYSINS_SYNC; // [RQ6]
                     end
                  end
                  sysins_pkg::SYSINS_OP_FETCH_BARRIER:
                  begin
                     next_r.flush = 1'b1; // [RQ8]
                  end
                  sysins_pkg::SYSINS_OP_SPECIAL_READ:
                  begin
                     next_r.read_valid = 1'b1;
                     case (op_spec)
                        sysins_pkg::SPEC_STATUS: next_r.read_data = r.status;
                        sysins_pkg::SPEC_INT_MASK: next_r.read_data = {31'h0, r.int_mask};
                        sysins_pkg::SPEC_FAULT_MASK: next_r.read_data = {31'h0, r.fault_mask};
                        sysins_pkg::SPEC_PRIO_LEVEL,
                        sysins_pkg::SPEC_PRIO_RAISE: next_r.read_data = {24'h0, r.prio}; // [RQ9]
                        sysins_pkg::SPEC_CONTROL: next_r.read_data = r.control;
                        default: next_r.read_data = 32'h00000000;
                     endcase
                  end
                  sysins_pkg::SYSINS_OP_SPECIAL_WRITE:
                  begin
                     if (op_spec == sysins_pkg::SPEC_STATUS)
                     begin
                        // Flags taken straight from the source word
                        next_r.status = op_src & sysins_pkg::STATUS_APP_MASK; // [RQ11] [RQ13]
                     end
                     else if (op_privileged) // [RQ10]
                     begin
                        case (op_spec)
                           sysins_pkg::SPEC_INT_MASK: next_r.int_mask = op_src[0];
                           sysins_pkg::SPEC_FAULT_MASK: next_r.fault_mask = op_src[0];
                           sysins_pkg::SPEC_PRIO_LEVEL: next_r.prio = op_src[7:0];
                           sysins_pkg::SPEC_PRIO_RAISE:
                           begin
                              if (raise_ok(r.prio, op_src[7:0]))
                              begin
                                 next_r.prio = op_src[7:0]; // [RQ12]
                              end
                           end
                           sysins_pkg::SPEC_CONTROL: next_r.control = op_src;
                           default: next_r.control = r.control;
                        endcase
                     end
                  end
                  sysins_pkg::SYSINS_OP_SEND_EVENT:
                  begin
                     next_r.event_out = 1'b1; // [RQ15]
                     next_r.event_reg = 1'b1; // [RQ15]
                  end
                  sysins_pkg::SYSINS_OP_SUPERVISOR_CALL:
                  begin
                     next_r.supervisor_call_op = 1'b1; // [RQ16]
                  end
                  sysins_pkg::SYSINS_OP_WAIT_EVENT:
                  begin
                     if (r.event_reg || event_in)
                     begin
                        next_r.event_reg = 1'b0; // [RQ18]
                     end
                     else if (!wake_event)
                     begin
                        next_r.state = SYSINS_WAIT_EV; // [RQ17]
                     end
                  end
                  sysins_pkg::SYSINS_OP_WAIT_INTERRUPT:
                  begin
                     if (!wake_int)
                     begin
                        next_r.state = SYSINS_WAIT_INT; // [RQ19]
                     end
                  end
                  default:
                  begin
                     // No-operation and memory ops finish at once
                     next_r.state = SYSINS_RUN; // [RQ14]
                  end
               endcase
            end
         end
         SYSINS_SYNC:
         begin
            if (mem_outstanding == 4'h0)
            begin
               next_r.state = SYSINS_RUN; // [RQ7]
            end
         end
         SYSINS_WAIT_EV:
         begin
            if (wake_event)
            begin
               next_r.state = SYSINS_RUN; // [RQ17]
            end
         end
         SYSINS_WAIT_INT:
         begin
            if (wake_int)
            begin
               next_r.state = SYSINS_RUN; // [RQ19]
            end
         end
         default:
         begin
            next_r.state = SYSINS_RUN;
         end
      endcase
      // Outside events latch the register; a consuming wait-event clear wins over the set
      if (event_in && !(accept && op_code == sysins_pkg::SYSINS_OP_WAIT_EVENT))
      begin
         next_r.event_reg = 1'b1;
      end
      // APB writes: control bits; reads return live state
      if (apb_access && pwrite && paddr == sysins_pkg::REG_CTRL)
      begin
         next_r.ctrl = pwdata[1:0];
      end
      if (psel && !penable && !pwrite)
      begin
         case (paddr)
            sysins_pkg::REG_CTRL: next_r.prdata = {30'h0, r.ctrl};
            sysins_pkg::REG_STATE: next_r.prdata = {26'h0, r.event_reg, r.order_hold,
               r.fault_mask, r.int_mask, r.state};
            sysins_pkg::REG_STATUS: next_r.prdata = r.status;
            sysins_pkg::REG_PRIO: next_r.prdata = {24'h0, r.prio};
            sysins_pkg::REG_CONTROL: next_r.prdata = r.control;
            default: next_r.prdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '{state: SYSINS_RUN, int_mask: 1'b0, fault_mask: 1'b0,
            prio: sysins_pkg::PRIO_RESET, status: sysins_pkg::STATUS_RESET,
            control: 32'h00000000, event_reg: 1'b0, order_hold: 1'b0,
            ctrl: sysins_pkg::CTRL_RESET, read_data: 32'h00000000, read_valid: 1'b0,
            flush: 1'b0, event_out: 1'b0, supervisor_call_op: 1'b0, prdata: 32'h00000000};
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs from flip-flops
   always_comb
   begin
      read_data = r.read_data;
      read_valid = r.read_valid;
      pipe_flush = r.flush;
      event_out = r.event_out;
      svc_raise = r.supervisor_call_op;
      int_mask = r.int_mask;
      fault_mask = r.fault_mask;
      prio_level = r.prio;
      prdata = r.prdata;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   unpriv_cps_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_CHANGE_STATE && !op_privileged
      |=> $stable(int_mask) && $stable(fault_mask))
      else $error("unprivileged change-state altered masks"); // [RQ2]
   cps_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_CHANGE_STATE && op_privileged
      && op_flags[0] |=> int_mask == $past(op_set))
      else $error("change-state did not update interrupt mask"); // [RQ1]
   sync_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_SYNC_BARRIER && mem_outstanding != 4'h0
      |=> !op_ready)
      else $error("sync barrier did not stall"); // [RQ6]
   sync_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      r.state == SYSINS_SYNC && mem_outstanding == 4'h0 |=> op_ready)
      else $error("sync barrier did not release"); // [RQ7]
   order_free_a: assert property (@(posedge pclk) disable iff (!presetn)
      r.order_hold && r.state == SYSINS_RUN |-> op_ready && !mem_issue_ok)
      else $error("order barrier mishandled"); // [RQ4] [RQ5]
   flush_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_FETCH_BARRIER |=> pipe_flush
      ##1 (!pipe_flush || $past(accept && op_code == sysins_pkg::SYSINS_OP_FETCH_BARRIER)))
      else $error("fetch barrier flush missing"); // [RQ8]
   raise_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_SPECIAL_WRITE && op_privileged
      && op_spec == sysins_pkg::SPEC_PRIO_RAISE && !raise_ok(prio_level, op_src[7:0])
      |=> $stable(prio_level))
      else $error("raise alias lowered priority"); // [RQ12]
   sev_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_SEND_EVENT |=> event_out && r.event_reg)
      else $error("send-event missing"); // [RQ15]
   svc_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_SUPERVISOR_CALL |=> svc_raise)
      else $error("supervisor call not raised"); // [RQ16]
   wfe_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      accept && op_code == sysins_pkg::SYSINS_OP_WAIT_EVENT && r.event_reg && !event_in
      |=> !r.event_reg && op_ready)
      else $error("wait-event with event set did not continue"); // [RQ18]
   wfi_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      r.state == SYSINS_WAIT_INT && debug_req |=> op_ready)
      else $error("debug request did not wake wait-interrupt"); // [RQ19]

endmodule // sysins_unit

// [bench/siu_mem_model.sv]
// Far-side memory model: keeps the count of explicit accesses in flight.
// Assumes the bench requests accesses; one retires every lat+1 cycles.
`timescale 1ns/1ps

module siu_mem_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic [3:0] lat,
   input wire logic mem_issue_ok,
   output logic [3:0] mem_outstanding
);
   logic [3:0] timer;
   logic retire;

   ////////////////////////////////////////////////////////////////////////////
   // Accept only while the unit lets accesses go; slow retire keeps barriers busy
   assign retire = (timer == 4'h0) && (mem_outstanding != 4'h0);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_outstanding <= 4'h0;
         timer <= 4'h0;
      end
      else
      begin
         timer <= (timer == 4'h0) ? lat : timer - 4'h1;
         mem_outstanding <= mem_outstanding + 4'(req && mem_issue_ok) - 4'(retire);
      end
   end
endmodule // siu_mem_model

// [bench/system_instruction_unit_tb.sv]
// Bench for the system instruction unit: random and corner stimulus.
// Assumes the memory model on the far side and a zero-wait APB port.
`timescale 1ns/1ps

module system_instruction_unit_tb;
   logic pclk = 1'h0, presetn = 1'h0, op_valid = 1'h0, op_set = 1'h0, op_privileged = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, req = 1'h0, event_in = 1'h0;
   logic exc_unmasked = 1'h0, exc_pending = 1'h0, exc_any = 1'h0, debug_req = 1'h0;
   sysins_pkg::sysins_op_t op_code = sysins_pkg::SYSINS_OP_NONE;
   logic [1:0] op_flags = 2'h0, em = 2'h0;
   logic [3:0] op_spec = 4'h0, lat = 4'h4, mem_outstanding, oc;
   logic [7:0] op_imm = 8'h00, paddr = 8'h00, prio_level, p, e = 8'h00;
   logic [31:0] op_src = 32'h0, pwdata = 32'h0, read_data, prdata, rd, v, st;
   logic op_ready, read_valid, mem_issue_ok, pipe_flush, event_out, svc_raise, sleeping;
   logic int_mask, fault_mask, pready, pslverr;
   int err_total = 0, cmp_count = 0, seed = 32'hA8AC, n;
   sysins_pkg::sysins_op_t c;
   logic [3:0] ops [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
   logic [7:0] tab [5] = '{8'h00, 8'h90, 8'hA0, 8'h90, 8'h10};

   sysins_unit dut
   (
      .pclk(pclk), .presetn(presetn), .op_valid(op_valid), .op_code(op_code),
      .op_flags(op_flags), .op_set(op_set), .op_spec(op_spec), .op_src(op_src),
      .op_imm(op_imm), .op_privileged(op_privileged), .op_ready(op_ready),
      .read_data(read_data), .read_valid(read_valid), .mem_outstanding(mem_outstanding),
      .mem_issue_ok(mem_issue_ok), .pipe_flush(pipe_flush), .event_out(event_out),
      .event_in(event_in), .svc_raise(svc_raise), .exc_unmasked(exc_unmasked),
      .exc_pending(exc_pending), .exc_any(exc_any), .debug_req(debug_req),
      .sleeping(sleeping), .int_mask(int_mask), .fault_mask(fault_mask),
      .prio_level(prio_level), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   siu_mem_model mem
   (
      .pclk(pclk), .presetn(presetn), .req(req), .lat(lat),
      .mem_issue_ok(mem_issue_ok), .mem_outstanding(mem_outstanding)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the guard spans far more than the tests need
   initial forever #10 pclk = ~pclk;
   initial
   begin
      #400000;
      err_total++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Sample handshakes at the falling edge, where they are settled
   task automatic sync(input int k);
      n = 0;
      @(negedge pclk);
      while ((k == 0 ? op_ready : k == 1 ? mem_issue_ok : pready) !== 1'h1 && n < 200)
      begin
         n++;
         @(negedge pclk);
      end
      check("handshake", n < 200, 1'h1);
      rd = prdata;
      oc = mem_outstanding;
      @(posedge pclk);
   endtask

   // One instruction; ends in the cycle where its pulses show
   task automatic op(input logic [3:0] cd, input logic [31:0] src = 32'h0,
      input logic [3:0] spec = 4'h0, input logic [1:0] fl = 2'h0,
      input logic set = 1'h0, input logic pv = 1'h1);
      @(posedge pclk);
      op_valid <= 1'h1;
      op_code <= sysins_pkg::sysins_op_t'(cd);
      op_src <= src;
      op_spec <= spec;
      op_flags <= fl;
      op_set <= set;
      op_privileged <= pv;
      op_imm <= 8'($random(seed));
      sync(0);
      op_valid <= 1'h0;
      @(negedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      sync(2);
      check("pslverr", pslverr, 1'h0);
      psel <= 1'h0;
      penable <= 1'h0;
      @(negedge pclk);
   endtask

   task automatic mem_access;
      @(posedge pclk);
      req <= 1'h1;
      sync(1);
      req <= 1'h0;
      @(negedge pclk);
   endtask

   // Level kept by a write through the raise alias
   function automatic logic [7:0] raise(input logic [7:0] cur, input logic [7:0] nv);
      return (nv != 8'h00 && (cur == 8'h00 || nv < cur)) ? nv : cur;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 8'h40);
      check("unmapped", rd, 32'h0);
      // Mask changes: user level first must do nothing
      for (int f = 1; f < 4; f++)
         for (int s = 1; s >= 0; s--)
         begin
            op(4'h1, 32'h0, 4'h0, 2'(f), 1'(s), 1'h0);
            check("cps_user", {fault_mask, int_mask}, em);
            op(4'h1, 32'h0, 4'h0, 2'(f), 1'(s));
            em = s ? (em | 2'(f)) : (em & ~2'(f));
            check("cps", {fault_mask, int_mask}, em);
         end
      $display("test change_state done");
      // Status word writes at both levels, mask write at user level
      v = $random(seed);
      op(4'h6, v, sysins_pkg::SPEC_STATUS, 2'h0, 1'h0, 1'h0);
      apb(1'h0, sysins_pkg::REG_STATUS);
      check("status_user", rd, v & sysins_pkg::STATUS_APP_MASK);
      v = $random(seed);
      st = v & sysins_pkg::STATUS_APP_MASK;
      op(4'h6, v, sysins_pkg::SPEC_STATUS);
      apb(1'h0, sysins_pkg::REG_STATUS);
      check("status", rd, st);
      op(4'h6, 32'h1, sysins_pkg::SPEC_INT_MASK, 2'h0, 1'h0, 1'h0);
      check("mask_user", int_mask, 1'h0);
      op(4'h6, 32'h1, sysins_pkg::SPEC_INT_MASK);
      check("mask_priv", int_mask, 1'h1);
      $display("test special_write done");
      // Flag-neutral ops, with their pulses and no stall
      for (int i = 0; i < 8; i++)
      begin
         c = sysins_pkg::sysins_op_t'(ops[i]);
         op(ops[i]);
         check("flush", pipe_flush, c == sysins_pkg::SYSINS_OP_FETCH_BARRIER);
         check("event", event_out, c == sysins_pkg::SYSINS_OP_SEND_EVENT);
         check("svc", svc_raise, c == sysins_pkg::SYSINS_OP_SUPERVISOR_CALL);
         if (c != sysins_pkg::SYSINS_OP_SYNC_BARRIER)
            check("no_stall", op_ready, 1'h1);
      end
      apb(1'h0, sysins_pkg::REG_STATE);
      check("event_reg", rd[5], 1'h1);
      op(4'hA);
      check("wfe_pass", sleeping, 1'h0);
      apb(1'h0, sysins_pkg::REG_STATE);
      check("event_clr", rd[5], 1'h0);
      apb(1'h0, sysins_pkg::REG_STATUS);
      check("flags_kept", rd, st);
      $display("test neutral_ops done");
      // Raise alias: corner table, then random values
      for (int i = 0; i < 9; i++)
      begin
         p = i < 5 ? tab[i] : 8'($random(seed));
         op(4'h6, {24'h0, p}, sysins_pkg::SPEC_PRIO_RAISE);
         e = raise(e, p);
         check("prio", prio_level, e);
         op(4'h5, 32'h0, sysins_pkg::SPEC_PRIO_RAISE);
         check("raise_read", read_data, {24'h0, e});
         check("read_valid", read_valid, 1'h1);
      end
      $display("test priority done");
      // Sleep on wait-event, woken by each source in turn
      apb(1'h1, sysins_pkg::REG_CTRL, 32'h3);
      for (int k = 0; k < 4; k++)
      begin
         op(4'hA);
         repeat (3) @(negedge pclk);
         check("wfe_sleep", {sleeping, op_ready}, 2'h2);
         @(posedge pclk);
         {event_in, debug_req, exc_pending, exc_unmasked} <= 4'h1 << k;
         sync(0);
         check("wfe_wake", sleeping, 1'h0);
         {event_in, debug_req, exc_pending, exc_unmasked} <= 4'h0;
      end
      // Wait-interrupt: debug wakes even with debug disabled
      apb(1'h1, sysins_pkg::REG_CTRL, 32'h0);
      // Event latched by the last wake lets one wait-event pass
      op(4'hA);
      check("wfe_again", sleeping, 1'h0);
      // With both gates off, pending and debug must not wake it
      op(4'hA);
      @(posedge pclk);
      {debug_req, exc_pending} <= 2'h3;
      repeat (3) @(negedge pclk);
      check("wfe_gated", sleeping, 1'h1);
      @(posedge pclk);
      {debug_req, exc_pending, exc_unmasked} <= 3'h1;
      sync(0);
      check("wfe_unmasked", sleeping, 1'h0);
      exc_unmasked <= 1'h0;
      for (int k = 0; k < 2; k++)
      begin
         op(4'hB);
         repeat (3) @(negedge pclk);
         check("wfi_sleep", sleeping, 1'h1);
         @(posedge pclk);
         {debug_req, exc_any} <= 2'h1 << k;
         sync(0);
         check("wfi_wake", sleeping, 1'h0);
         {debug_req, exc_any} <= 2'h0;
      end
      $display("test sleep done");
      // Barriers with slow retirement on the far side
      lat <= 4'h4 + 4'($random(seed) & 3);
      repeat (3) mem_access();
      op(4'h3);
      check("dsb_stall", op_ready, 1'h0);
      sync(0);
      check("dsb_done", oc, 4'h0);
      repeat (2) mem_access();
      op(4'h2);
      check("dmb_run", op_ready, 1'h1);
      check("dmb_hold", mem_issue_ok, 1'h0);
      mem_access();
      check("dmb_order", oc, 4'h0);
      $display("test barriers done");
      finish_test();
   end
endmodule // system_instruction_unit_tb
